// ---- rtl/cpuc_pkg.sv ----
// Shared constants and types of the conversion period update control.
package cpuc_pkg;
  // Word layout on the host serial link.
  localparam int         WORD_W        = 16;
  localparam int         SEL_LSB       = 13;
  localparam int         DATA_LSB      = 2;
  localparam int         SINX_BIT      = 9;
  localparam logic [1:0] PRI_NORMAL    = 2'h0;
  localparam logic [1:0] PRI_ADJ_ADD   = 2'h1;
  localparam logic [1:0] PRI_ADJ_SUB   = 2'h2;
  localparam logic [1:0] PRI_SECONDARY = 2'h3;
  localparam logic [2:0] SEL_TX_A      = 3'h0;
  localparam logic [2:0] SEL_TX_ADJ    = 3'h1;
  localparam logic [2:0] SEL_TX_B      = 3'h2;
  localparam logic [2:0] SEL_RX_A      = 3'h3;
  localparam logic [2:0] SEL_RX_ADJ    = 3'h4;
  localparam logic [2:0] SEL_RX_B      = 3'h5;
  localparam logic [2:0] SEL_CTRL      = 3'h6;
  // Divisor reset values and the B divisor floor.
  localparam logic [7:0] RST_TX_A      = 8'h12;
  localparam logic [7:0] RST_TX_ADJ    = 8'h01;
  localparam logic [7:0] RST_TX_B      = 8'h12;
  localparam logic [7:0] RST_RX_A      = 8'h12;
  localparam logic [7:0] RST_RX_ADJ    = 8'h01;
  localparam logic [7:0] RST_RX_B      = 8'h12;
  localparam logic [7:0] B_MIN         = 8'h0f;
  localparam logic [7:0] B_FIX         = 8'h12;
  // A counter value at which a pending adjustment is applied.
  localparam logic [7:0] ADJ_POINT     = 8'h02;
  // Register port offsets.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_TX_DIV    = 8'h08;
  localparam logic [7:0] REG_RX_DIV    = 8'h0c;
  localparam logic [7:0] REG_DROPS     = 8'h10;
  localparam logic       RUN_RST       = 1'b0;
  // Timing.
  localparam int         SYS_CLK_NS    = 8;
  localparam int         SHIFT_CLK_NS  = 256;
  localparam int         SHIFT_HALF    = SHIFT_CLK_NS / (2 * SYS_CLK_NS);
  localparam int         RX_MARGIN_CYC = 64;
  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_DONE  = 3'b100
  } cpuc_ser_state_t;
endpackage

// ---- rtl/cpuc_period_if.sv ----
// Interface between the top control and one conversion period counter.
`timescale 1ns/1ps
interface cpuc_period_if;
  logic        run;
  logic [7:0]  div_a;
  logic [7:0]  div_b;
  logic [7:0]  adj;
  logic [1:0]  op;
  logic        decide;
  logic        period_end;
  logic [15:0] remain;
  modport ctr  (input run, div_a, div_b, adj, op, output decide, period_end, remain);
  modport user (output run, div_a, div_b, adj, op, input decide, period_end, remain);
endinterface

// ---- rtl/cpuc_sync3.sv ----
// Three-stage synchroniser that accepts a change once two stages agree.
`timescale 1ns/1ps
module cpuc_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Pin side and clean side
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      sync_out <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end
endmodule

// ---- rtl/cpuc_period_ctr.sv ----
// Conversion period counter: B prescales the clock, A counts the period.
`timescale 1ns/1ps
module cpuc_period_ctr (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   rst_n,
  // Divisors in, period events out
  cpuc_period_if.ctr pif
);
  logic       tick;
  logic [7:0] a_cnt_r;
  logic [7:0] pre_cnt_r;
  logic [8:0] sum_add;
  logic [8:0] dif_sub;
  logic       adj_done_r;

  assign tick           = pif.run && (pre_cnt_r == 8'h00);
  // One decision per period: an added count passes the decision point again, and
  // without this guard the same adjustment would stretch the period forever.
  assign pif.decide     = tick && (a_cnt_r == cpuc_pkg::ADJ_POINT) && !adj_done_r;
  assign pif.period_end = tick && (a_cnt_r <= 8'h01);
  assign sum_add = {1'b0, cpuc_pkg::ADJ_POINT} - 9'h001 + {1'b0, pif.adj};
  assign dif_sub = {1'b0, cpuc_pkg::ADJ_POINT} - 9'h001 - {1'b0, pif.adj};
  // Remaining time to the decision point, in clock cycles: counts left times div_b.
  assign pif.remain = (a_cnt_r > cpuc_pkg::ADJ_POINT && !adj_done_r) ?
                      {8'h00, a_cnt_r - cpuc_pkg::ADJ_POINT} * {8'h00, pif.div_b} : 16'h0000;

  // A result that would reach zero or overflow is refused and the plain count is kept.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      a_cnt_r   <= 8'h00;
      pre_cnt_r <= 8'h00;
    end else if (!pif.run) begin
      a_cnt_r   <= pif.div_a;
      pre_cnt_r <= pif.div_b - 8'h01;
    end else if (tick) begin
      pre_cnt_r <= pif.div_b - 8'h01;
      if (a_cnt_r <= 8'h01) begin
        a_cnt_r <= pif.div_a;
      end else if (pif.decide && pif.op == cpuc_pkg::PRI_ADJ_ADD && !sum_add[8]) begin
        a_cnt_r <= sum_add[7:0];
      end else if (pif.decide && pif.op == cpuc_pkg::PRI_ADJ_SUB && !dif_sub[8] &&
                   dif_sub != 9'h000) begin
        a_cnt_r <= dif_sub[7:0];
      end else begin
        a_cnt_r <= a_cnt_r - 8'h01;
      end
    end else begin
      pre_cnt_r <= pre_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adj_done_r <= 1'b0;
    end else if (!pif.run || pif.period_end) begin
      adj_done_r <= 1'b0;
    end else if (pif.decide) begin
      adj_done_r <= 1'b1;
    end
  end

  near_end_add_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pif.decide && pif.op == cpuc_pkg::PRI_ADJ_ADD && pif.adj == 8'h03 |=>
    a_cnt_r == 8'h04)
    else $error("Add adjustment not applied at the decision point.");
endmodule

// ---- rtl/cpuc_top.sv ----
// Conversion period update control: host word intake, period steering, filter select.
//
// Notes on behaviour
// - The transmit part of an adjustment hits the running transmit period.
// - Adjustments are applied near the end of a period, never at its start.
// - Enough time before the receive decision point: adjust the current receive period.
// - Too little time left: adjust the following receive period instead.
// - Receive part is dropped if the current receive period is already adjusted.
// - Transmit divisors, adjust and control words act in the running transmit period.
// - Receive divisor and adjust values go to this or next period, by time left.
// - Further receive values in an already updated receive period are ignored.
// - Bit 9 of the secondary control word inserts or bypasses the correction filter.
// - When inserted, the correction filter feeds the low-pass filter stage.
// - Reset loads divisors 12, 01, 12 and 12, 01, 12 hex.
// - A B divisor written below 15 is replaced by 12 hex.
`timescale 1ns/1ps
module cpuc_top #(
  parameter int RX_MARGIN  = cpuc_pkg::RX_MARGIN_CYC,
  parameter int SHIFT_HALF = cpuc_pkg::SHIFT_HALF
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Serial link to the host
  input  wire logic        host_serial_data_in,
  output logic             transmit_frame_sync_n,
  output logic             shift_clk,
  output logic             receive_frame_sync_n,
  // Output signal path
  input  wire logic [15:0] dac_direct,
  input  wire logic [15:0] dac_corrected,
  output logic      [15:0] scf_in,
  output logic             sinx_insert,
  output logic      [13:0] dac_code
);
  cpuc_period_if tx_if ();
  cpuc_period_if rx_if ();

  cpuc_pkg::cpuc_ser_state_t ser_state_r;
  logic        data_s;
  logic [7:0]  half_cnt_r;
  logic [3:0]  bit_cnt_r;
  logic [15:0] shreg_r;
  logic        shift_clk_r;
  logic        sec_expect_r;
  logic        run_r;
  logic [7:0]  tx_a_r;
  logic [7:0]  tx_adj_r;
  logic [7:0]  tx_b_r;
  logic [1:0]  tx_op_r;
  logic        sinx_r;
  logic [7:0]  rx_a_r;
  logic [7:0]  rx_adj_r;
  logic [7:0]  rx_b_r;
  logic [1:0]  rx_op_r;
  logic        cur_taken_r;
  logic        nxt_pend_r;
  logic [7:0]  st_a_r;
  logic [7:0]  st_adj_r;
  logic [7:0]  st_b_r;
  logic [1:0]  st_op_r;
  logic [15:0] drop_cnt_r;
  logic [31:0] rdata_r;
  logic [15:0] scf_in_r;
  logic [13:0] dac_code_r;
  logic        rfs_n_r;
  logic        word_vld;
  logic        is_pri;
  logic        is_sec;
  logic [2:0]  sel;
  logic [7:0]  fld;
  logic [1:0]  mode;
  logic        adj_cmd;
  logic        rx_upd;
  logic        rx_take_cur;
  logic        rx_take_nxt;
  logic        rx_drop;
  logic [7:0]  pk_a;
  logic [7:0]  pk_adj;
  logic [7:0]  pk_b;
  logic [1:0]  pk_op;
  logic [31:0] rd_mux;

  // True for secondary selects that address a receive register.
  function automatic logic is_rx_sel(input logic [2:0] s);
    return (s == cpuc_pkg::SEL_RX_A) || (s == cpuc_pkg::SEL_RX_ADJ) ||
           (s == cpuc_pkg::SEL_RX_B);
  endfunction

  // A B divisor below the floor would stall the filter clock, so it is forced.
  function automatic logic [7:0] fix_b(input logic [7:0] v);
    return (v < cpuc_pkg::B_MIN) ? cpuc_pkg::B_FIX : v;
  endfunction

  cpuc_sync3 #(
    .WIDTH (1)
  ) u_data_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (host_serial_data_in),
    .sync_out (data_s)
  );

  cpuc_period_ctr u_tx_ctr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pif     (tx_if.ctr)
  );

  cpuc_period_ctr u_rx_ctr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pif     (rx_if.ctr)
  );

  assign tx_if.run   = run_r;
  assign tx_if.div_a = tx_a_r;
  assign tx_if.div_b = tx_b_r;
  assign tx_if.adj   = tx_adj_r;
  assign tx_if.op    = tx_op_r;
  assign rx_if.run   = run_r;
  assign rx_if.div_a = rx_a_r;
  assign rx_if.div_b = rx_b_r;
  assign rx_if.adj   = rx_adj_r;
  assign rx_if.op    = rx_op_r;

  // A transmit period end opens a frame when none is open; the host's word is shifted in during it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ser_state_r <= cpuc_pkg::SER_IDLE;
      half_cnt_r  <= 8'h00;
      bit_cnt_r   <= 4'h0;
      shreg_r     <= 16'h0000;
      shift_clk_r <= 1'b0;
    end else begin
      unique case (ser_state_r)
        cpuc_pkg::SER_IDLE: begin
          if (tx_if.period_end) begin
            ser_state_r <= cpuc_pkg::SER_SHIFT;
            half_cnt_r  <= 8'h00;
            bit_cnt_r   <= 4'h0;
          end
        end
        cpuc_pkg::SER_SHIFT: begin
          if (half_cnt_r == 8'(SHIFT_HALF - 1)) begin
            half_cnt_r  <= 8'h00;
            shift_clk_r <= ~shift_clk_r;
            // Sampling on the falling edge leaves half a bit for the synchroniser delay.
            if (shift_clk_r) begin
              shreg_r   <= {shreg_r[14:0], data_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == 4'hf) begin
                ser_state_r <= cpuc_pkg::SER_DONE;
              end
            end
          end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
          end
        end
        cpuc_pkg::SER_DONE: begin
          ser_state_r <= cpuc_pkg::SER_IDLE;
        end
      endcase
    end
  end

  assign word_vld = (ser_state_r == cpuc_pkg::SER_DONE);
  assign is_pri   = word_vld && !sec_expect_r;
  assign is_sec   = word_vld && sec_expect_r;
  assign sel      = shreg_r[cpuc_pkg::SEL_LSB +: 3];
  assign fld      = shreg_r[cpuc_pkg::DATA_LSB +: 8];
  assign mode     = shreg_r[1:0];
  assign adj_cmd  = is_pri && (mode == cpuc_pkg::PRI_ADJ_ADD || mode == cpuc_pkg::PRI_ADJ_SUB);
  assign rx_upd   = adj_cmd || (is_sec && is_rx_sel(sel));

  // A primary word may announce that the next frame carries a secondary word.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sec_expect_r <= 1'b0;
      dac_code_r   <= 14'h0000;
    end else if (word_vld) begin
      sec_expect_r <= is_pri && (mode == cpuc_pkg::PRI_SECONDARY);
      if (is_pri) begin
        dac_code_r <= shreg_r[15:2];
      end
    end
  end

  // Transmit values act at once, inside the period that is running.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_a_r   <= cpuc_pkg::RST_TX_A;
      tx_adj_r <= cpuc_pkg::RST_TX_ADJ;
      tx_b_r   <= cpuc_pkg::RST_TX_B;
      sinx_r   <= 1'b0;
    end else if (is_sec) begin
      case (sel)
        cpuc_pkg::SEL_TX_A:   tx_a_r   <= fld;
        cpuc_pkg::SEL_TX_ADJ: tx_adj_r <= fld;
        cpuc_pkg::SEL_TX_B:   tx_b_r   <= fix_b(fld);
        cpuc_pkg::SEL_CTRL:   sinx_r   <= shreg_r[cpuc_pkg::SINX_BIT];
        default: begin
        end
      endcase
    end
  end

  // A command arriving with the period end still wins; it belongs to the new period.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_op_r <= cpuc_pkg::PRI_NORMAL;
    end else if (adj_cmd) begin
      tx_op_r <= mode;
    end else if (tx_if.period_end) begin
      tx_op_r <= cpuc_pkg::PRI_NORMAL;
    end
  end

  // Build the receive update on top of whatever is already queued.
  always_comb begin
    pk_a   = nxt_pend_r ? st_a_r   : rx_a_r;
    pk_adj = nxt_pend_r ? st_adj_r : rx_adj_r;
    pk_b   = nxt_pend_r ? st_b_r   : rx_b_r;
    pk_op  = nxt_pend_r ? st_op_r  : cpuc_pkg::PRI_NORMAL;
    if (adj_cmd) begin
      pk_op = mode;
    end else begin
      case (sel)
        cpuc_pkg::SEL_RX_A:   pk_a   = fld;
        cpuc_pkg::SEL_RX_ADJ: pk_adj = fld;
        cpuc_pkg::SEL_RX_B:   pk_b   = fix_b(fld);
        default: begin
        end
      endcase
    end
  end

  assign rx_drop     = rx_upd && cur_taken_r;
  assign rx_take_cur = rx_upd && !cur_taken_r && !nxt_pend_r &&
                       (rx_if.remain > 16'(RX_MARGIN));
  assign rx_take_nxt = rx_upd && !cur_taken_r && !rx_take_cur;

  // The counter reads the op at its decision point, so an update written now lands
  // near the end of the period it targets.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_a_r      <= cpuc_pkg::RST_RX_A;
      rx_adj_r    <= cpuc_pkg::RST_RX_ADJ;
      rx_b_r      <= cpuc_pkg::RST_RX_B;
      rx_op_r     <= cpuc_pkg::PRI_NORMAL;
      st_a_r      <= cpuc_pkg::RST_RX_A;
      st_adj_r    <= cpuc_pkg::RST_RX_ADJ;
      st_b_r      <= cpuc_pkg::RST_RX_B;
      st_op_r     <= cpuc_pkg::PRI_NORMAL;
      cur_taken_r <= 1'b0;
      nxt_pend_r  <= 1'b0;
    end else if (rx_if.period_end) begin
      nxt_pend_r <= 1'b0;
      if (rx_take_nxt) begin
        {rx_a_r, rx_adj_r, rx_b_r, rx_op_r} <= {pk_a, pk_adj, pk_b, pk_op};
        cur_taken_r <= 1'b1;
      end else if (nxt_pend_r) begin
        {rx_a_r, rx_adj_r, rx_b_r, rx_op_r} <= {st_a_r, st_adj_r, st_b_r, st_op_r};
        cur_taken_r <= 1'b1;
      end else begin
        rx_op_r     <= cpuc_pkg::PRI_NORMAL;
        cur_taken_r <= 1'b0;
      end
    end else if (rx_take_cur) begin
      {rx_a_r, rx_adj_r, rx_b_r, rx_op_r} <= {pk_a, pk_adj, pk_b, pk_op};
      cur_taken_r <= 1'b1;
    end else if (rx_take_nxt) begin
      {st_a_r, st_adj_r, st_b_r, st_op_r} <= {pk_a, pk_adj, pk_b, pk_op};
      nxt_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drop_cnt_r <= 16'h0000;
    end else if (rx_drop) begin
      drop_cnt_r <= drop_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scf_in_r <= 16'h0000;
      rfs_n_r  <= 1'b1;
    end else begin
      scf_in_r <= sinx_r ? dac_corrected : dac_direct;
      rfs_n_r  <= ~rx_if.period_end;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_r <= cpuc_pkg::RUN_RST;
    end else if (reg_wr && reg_addr == cpuc_pkg::REG_CTRL) begin
      run_r <= reg_wdata[0];
    end
  end

  always_comb begin
    case (reg_addr)
      cpuc_pkg::REG_CTRL:   rd_mux = {31'h0, run_r};
      cpuc_pkg::REG_STATUS: rd_mux = {25'h0, ser_state_r, sec_expect_r, sinx_r,
                                      nxt_pend_r, cur_taken_r};
      cpuc_pkg::REG_TX_DIV: rd_mux = {6'h00, tx_op_r, tx_b_r, tx_adj_r, tx_a_r};
      cpuc_pkg::REG_RX_DIV: rd_mux = {6'h00, rx_op_r, rx_b_r, rx_adj_r, rx_a_r};
      cpuc_pkg::REG_DROPS:  rd_mux = {16'h0000, drop_cnt_r};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata             = rdata_r;
  assign transmit_frame_sync_n = (ser_state_r != cpuc_pkg::SER_SHIFT);
  assign shift_clk             = shift_clk_r;
  assign receive_frame_sync_n  = rfs_n_r;
  assign scf_in                = scf_in_r;
  assign sinx_insert           = sinx_r;
  assign dac_code              = dac_code_r;

  frame_open_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_if.period_end && ser_state_r == cpuc_pkg::SER_IDLE |=> !transmit_frame_sync_n)
    else $error("Frame did not open at the transmit period end.");
  tx_adjust_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    adj_cmd |=> tx_op_r == $past(mode) && tx_if.op == tx_op_r)
    else $error("Transmit adjustment not taken by the running period.");
  rx_current_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_upd && !cur_taken_r && !nxt_pend_r && !rx_if.period_end &&
    rx_if.remain > 16'(RX_MARGIN) |=> cur_taken_r && !nxt_pend_r)
    else $error("Receive update with time to spare missed the current period.");
  rx_next_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_upd && !cur_taken_r && !rx_if.period_end &&
    rx_if.remain <= 16'(RX_MARGIN) |=> nxt_pend_r && !cur_taken_r)
    else $error("Late receive update was not queued for the next period.");
  rx_discard_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_drop && !rx_if.period_end |=> $stable(rx_a_r) && $stable(rx_op_r) &&
    drop_cnt_r == $past(drop_cnt_r) + 16'h0001)
    else $error("Receive update in an adjusted period was not discarded.");
  tx_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_sec && sel == cpuc_pkg::SEL_TX_A |=> tx_if.div_a == $past(fld))
    else $error("Transmit A divisor did not act in the running period.");
  filter_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sinx_insert ##1 sinx_insert |-> scf_in == $past(dac_corrected))
    else $error("Inserted correction filter is not feeding the low-pass stage.");
  sinx_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_sec && sel == cpuc_pkg::SEL_CTRL |=> sinx_insert == $past(shreg_r[9]))
    else $error("Filter select does not follow bit 9 of the control word.");
  reset_vals_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> tx_a_r == 8'h12 && tx_adj_r == 8'h01 && tx_b_r == 8'h12 &&
    rx_a_r == 8'h12 && rx_adj_r == 8'h01 && rx_b_r == 8'h12)
    else $error("Divisor registers not at their reset values.");
  b_floor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_sec && sel == cpuc_pkg::SEL_TX_B && fld < 8'h0f |=> tx_b_r == 8'h12)
    else $error("Low transmit B divisor was not replaced.");
endmodule

// ---- sim/cpuc_host_model.sv ----
// Behavioural host that shifts queued words into the device inside frames.
`timescale 1ns/1ps
module cpuc_host_model (
  // Clock
  input  wire logic sys_clk,
  // Frame from the device
  input  wire logic transmit_frame_sync_n,
  input  wire logic shift_clk,
  // Data to the device
  output logic      host_serial_data_in
);
  logic [15:0] q[$];
  logic [15:0] cur;
  logic        in_frame = 1'b0;
  logic        sclk_q   = 1'b0;
  int          rises;
  initial host_serial_data_in = 1'b0;
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask
  always @(posedge sys_clk) begin
    sclk_q <= shift_clk;
    if (transmit_frame_sync_n) begin
      // Between frames the line toggles on every clock instead of holding a stale bit.
      in_frame <= 1'b0;
      host_serial_data_in <= ~host_serial_data_in;
    end else if (!in_frame) begin
      in_frame <= 1'b1;
      cur = (q.size() > 0) ? q.pop_front() : 16'h0000;
      rises = 0;
      host_serial_data_in <= cur[15];
    end else if (shift_clk && !sclk_q) begin
      // The first rise comes before any sample, so it moves nothing.
      rises = rises + 1;
      if (rises > 1 && rises < 17) host_serial_data_in <= cur[16 - rises];
    end
  end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench of the conversion period update control.
`timescale 1ns/1ps
module tb_top;
  localparam int SH = 7;
  logic        sys_clk, rst_n, reg_wr, reg_rd, host_serial_data_in;
  logic        transmit_frame_sync_n, shift_clk, receive_frame_sync_n, sinx_insert;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [15:0] dac_direct, dac_corrected, scf_in, rnd;
  logic [13:0] dac_code;
  logic [7:0]  exp_tx[3];
  logic [7:0]  exp_rx[3];
  int          bad_count   = 0;
  int          check_count = 0;
  int          drops       = 0;
  int          exp_len;
  time         t_open;

  cpuc_top #(.RX_MARGIN(8), .SHIFT_HALF(SH)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_serial_data_in(host_serial_data_in), .transmit_frame_sync_n(transmit_frame_sync_n),
    .shift_clk(shift_clk), .receive_frame_sync_n(receive_frame_sync_n),
    .dac_direct(dac_direct), .dac_corrected(dac_corrected), .scf_in(scf_in),
    .sinx_insert(sinx_insert), .dac_code(dac_code));

  cpuc_host_model host_u (.sys_clk(sys_clk), .transmit_frame_sync_n(transmit_frame_sync_n),
    .shift_clk(shift_clk), .host_serial_data_in(host_serial_data_in));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] floor_b(input logic [7:0] v);
    return (v < cpuc_pkg::B_MIN) ? 8'h12 : v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic divs();
    rd(cpuc_pkg::REG_TX_DIV);
    chk({8'h00, rv[23:0]}, {8'h00, exp_tx[2], exp_tx[1], exp_tx[0]});
    rd(cpuc_pkg::REG_RX_DIV);
    chk({8'h00, rv[23:0]}, {8'h00, exp_rx[2], exp_rx[1], exp_rx[0]});
  endtask

  task automatic send(input logic [15:0] w);
    wait (transmit_frame_sync_n === 1'b1);
    host_u.push(w);
    @(negedge transmit_frame_sync_n);
    t_open = $time;
    @(posedge transmit_frame_sync_n);
    repeat (8) @(posedge sys_clk);
    chk({31'h0, shift_clk}, 32'h0);
  endtask

  // A flagged primary word, then the secondary word it announces.
  task automatic sec(input logic [2:0] sel, input logic [7:0] val, input logic drop);
    logic [15:0] p;
    rnd = lfsr(rnd);
    p = {rnd[15:2], 2'h3};
    send(p);
    chk({18'h0, dac_code}, {18'h0, p[15:2]});
    send({sel, 3'h0, val, 2'h0});
    if (drop) drops++;
    else if (sel == cpuc_pkg::SEL_TX_A) exp_tx[0] = val;
    else if (sel == cpuc_pkg::SEL_TX_ADJ) exp_tx[1] = val;
    else if (sel == cpuc_pkg::SEL_TX_B) exp_tx[2] = floor_b(val);
    else if (sel == cpuc_pkg::SEL_RX_A) exp_rx[0] = val;
    else if (sel == cpuc_pkg::SEL_RX_ADJ) exp_rx[1] = val;
    else if (sel == cpuc_pkg::SEL_RX_B) exp_rx[2] = floor_b(val);
  endtask

  task automatic done(input string name);
    $display("test %s complete", name);
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rnd = 16'h0014;
    dac_direct = 16'h0;
    dac_corrected = 16'h0;
    exp_tx = '{8'h12, 8'h01, 8'h12};
    exp_rx = '{8'h12, 8'h01, 8'h12};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(cpuc_pkg::REG_TX_DIV, 32'hffffffff);
    divs();
    rd(8'h14);
    chk(rv, 32'h0);
    done("reset");
    wr(cpuc_pkg::REG_CTRL, 32'h1);
    sec(cpuc_pkg::SEL_TX_B, 8'h05, 1'b0);
    divs();
    sec(cpuc_pkg::SEL_TX_B, 8'h0f, 1'b0);
    sec(cpuc_pkg::SEL_TX_ADJ, rnd[9:2], 1'b0);
    divs();
    // An add command lengthens the running transmit period by the adjust count.
    sec(cpuc_pkg::SEL_TX_ADJ, 8'h03, 1'b0);
    rnd = lfsr(rnd);
    send({rnd[15:2], cpuc_pkg::PRI_ADJ_ADD});
    @(negedge transmit_frame_sync_n);
    exp_len = (int'(exp_tx[0]) + int'(exp_tx[1])) * int'(exp_tx[2]);
    chk(32'(($time - t_open) / 8), exp_len);
    done("transmit");
    for (int i = 0; i < 2; i++) begin
      sec(cpuc_pkg::SEL_CTRL, (i == 0) ? 8'h80 : 8'h00, 1'b0);
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      dac_direct <= rnd;
      dac_corrected <= ~rnd;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, sinx_insert}, (i == 0) ? 32'h1 : 32'h0);
      chk({16'h0, scf_in}, {16'h0, (i == 0) ? ~rnd : rnd});
    end
    done("filter");
    sec(cpuc_pkg::SEL_RX_B, 8'h0a, 1'b0);
    repeat (700) @(posedge sys_clk);
    divs();
    // A long receive period leaves room for two updates inside it.
    sec(cpuc_pkg::SEL_RX_A, 8'hff, 1'b0);
    // Two period ends leave a fresh long period with no update in it, whichever way
    // the divisor was steered.
    repeat (2) @(negedge receive_frame_sync_n);
    @(posedge sys_clk);
    #1 chk({31'h0, receive_frame_sync_n}, 32'h1);
    rd(cpuc_pkg::REG_STATUS);
    chk({30'h0, rv[1:0]}, 32'h0);
    sec(cpuc_pkg::SEL_RX_ADJ, 8'h05, 1'b0);
    sec(cpuc_pkg::SEL_RX_ADJ, 8'h07, 1'b1);
    divs();
    rd(cpuc_pkg::REG_DROPS);
    chk(rv, drops);
    done("receive");
    results();
  end
endmodule
